// >>> hdl/shared_gpio_port.sv
// Top of the shared general-purpose port bank: registers, read port and per-bank pad logic.
// Assumes a single-cycle register master and pad inputs synchronous to clk_sys.
// Assumes bank g occupies bits g*16 up to g*16+15 of every flat pad bus.
//
// Design decision made here: strobed register access.
module shared_gpio_port
  import gpio_port_pkg::*;
#(
  parameter logic [NUM_BANKS-1:0][BANK_W-1:0] BANK_MASK = IMPL_MASK
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire logic [ADDR_W-1:0]             reg_addr,
  input  wire logic [BANK_W-1:0]             reg_wdata,
  input  wire logic                          reg_write,
  input  wire logic                          reg_read,
  output logic      [BANK_W-1:0]             reg_rdata,
  input  wire logic [NUM_BANKS*BANK_W-1:0]   pad_in,
  output logic      [NUM_BANKS*BANK_W-1:0]   pad_out,
  output logic      [NUM_BANKS*BANK_W-1:0]   pad_oe,
  input  wire logic [NUM_BANKS*BANK_W-1:0]   periph_active,
  input  wire logic [NUM_BANKS*BANK_W-1:0]   periph_data,
  input  wire logic [NUM_BANKS*BANK_W-1:0]   analog_pin_config
);

  logic [NUM_BANKS-1:0][BANK_W-1:0] dir_q;
  logic [NUM_BANKS-1:0][BANK_W-1:0] lat_q;
  logic [NUM_BANKS-1:0][BANK_W-1:0] pins_q;
  logic [BANK_W-1:0]                rdata_q;
  logic [BANK_W-1:0]                rdata_d;
  reg_kind_t                        acc_kind;
  logic [BANK_SEL_W-1:0]            acc_bank;
  logic [BANK_SEL_W+1:0]            acc_dec;
  logic                             dir_wr;
  logic                             lat_wr;

  // Decodes a byte address into register kind and bank; unmatched gives none.
  function automatic logic [BANK_SEL_W+1:0] decode(input logic [ADDR_W-1:0] addr);
    logic [BANK_SEL_W+1:0] res;
    res = {KIND_NONE, {BANK_SEL_W{1'b0}}};
    case (addr)
      byte_addr(DIR_IDX[0]):   res = {KIND_DIR, 3'h0};
      byte_addr(DIR_IDX[1]):   res = {KIND_DIR, 3'h1};
      byte_addr(DIR_IDX[2]):   res = {KIND_DIR, 3'h2};
      byte_addr(DIR_IDX[3]):   res = {KIND_DIR, 3'h3};
      byte_addr(DIR_IDX[4]):   res = {KIND_DIR, 3'h4};
      byte_addr(DIR_IDX[5]):   res = {KIND_DIR, 3'h5};
      byte_addr(DIR_IDX[6]):   res = {KIND_DIR, 3'h6};
      byte_addr(PINS_IDX[0]):  res = {KIND_PINS, 3'h0};
      byte_addr(PINS_IDX[1]):  res = {KIND_PINS, 3'h1};
      byte_addr(PINS_IDX[2]):  res = {KIND_PINS, 3'h2};
      byte_addr(PINS_IDX[3]):  res = {KIND_PINS, 3'h3};
      byte_addr(PINS_IDX[4]):  res = {KIND_PINS, 3'h4};
      byte_addr(PINS_IDX[5]):  res = {KIND_PINS, 3'h5};
      byte_addr(PINS_IDX[6]):  res = {KIND_PINS, 3'h6};
      byte_addr(LATCH_IDX[0]): res = {KIND_LATCH, 3'h0};
      byte_addr(LATCH_IDX[1]): res = {KIND_LATCH, 3'h1};
      byte_addr(LATCH_IDX[2]): res = {KIND_LATCH, 3'h2};
      byte_addr(LATCH_IDX[3]): res = {KIND_LATCH, 3'h3};
      byte_addr(LATCH_IDX[4]): res = {KIND_LATCH, 3'h4};
      byte_addr(LATCH_IDX[5]): res = {KIND_LATCH, 3'h5};
      byte_addr(LATCH_IDX[6]): res = {KIND_LATCH, 3'h6};
      default: begin
        res = {KIND_NONE, {BANK_SEL_W{1'b0}}};
      end
    endcase
    return res;
  endfunction : decode

  always_comb begin
    acc_dec  = decode(reg_addr);
    acc_kind = reg_kind_t'(acc_dec[BANK_SEL_W+1:BANK_SEL_W]);
    acc_bank = acc_dec[BANK_SEL_W-1:0];
  end

  // Write strobes; a pin-value write is steered into the output latch.
  always_comb begin
    dir_wr = reg_write && (acc_kind == KIND_DIR);
    lat_wr = reg_write && (acc_kind == KIND_LATCH || acc_kind == KIND_PINS);
  end

  // Keeps only the implemented pins of the addressed bank.
  function automatic logic [BANK_W-1:0] impl_bits(input logic [BANK_W-1:0]     value,
                                                   input logic [BANK_SEL_W-1:0] bank);
    impl_bits = value & BANK_MASK[bank];
  endfunction : impl_bits

  // Direction registers.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= BANK_MASK;
    end else if (dir_wr) begin
      dir_q[acc_bank] <= impl_bits(reg_wdata, acc_bank);
    end
  end

  // Output latches; a write to either the latch or the pin-value register lands here.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lat_q <= {NUM_BANKS{LATCH_RST}};
    end else if (lat_wr) begin
      lat_q[acc_bank] <= impl_bits(reg_wdata, acc_bank);
    end
  end

  // Read data multiplexer.
  always_comb begin
    rdata_d = RDATA_RST;
    if (reg_read) begin
      case (acc_kind)
        KIND_DIR: begin
          rdata_d = dir_q[acc_bank] & BANK_MASK[acc_bank];
        end
        KIND_PINS: begin
          rdata_d = pins_q[acc_bank];
        end
        KIND_LATCH: begin
          rdata_d = lat_q[acc_bank] & BANK_MASK[acc_bank];
        end
        default: begin
          rdata_d = RDATA_RST;
        end
      endcase
    end
  end

  // Read data stand for exactly the cycle after the read strobe.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= RDATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Pad sampling and output multiplexing, one pair of instances per bank.
  // Bank A pin-value sampling.
  pin_sampler #(
    .W    (BANK_W),
    .MASK (BANK_MASK[0])
  ) sampler_a (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .pad_in     (pad_in[0*BANK_W +: BANK_W]),
    .analog_sel (analog_pin_config[0*BANK_W +: BANK_W]),
    .pins_q     (pins_q[0])
  );

  // Bank A output multiplexers.
  pad_driver #(
    .W    (BANK_W),
    .MASK (BANK_MASK[0])
  ) driver_a (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .dir           (dir_q[0]),
    .lat           (lat_q[0]),
    .periph_active (periph_active[0*BANK_W +: BANK_W]),
    .periph_data   (periph_data[0*BANK_W +: BANK_W]),
    .pad_out_q     (pad_out[0*BANK_W +: BANK_W]),
    .pad_oe_q      (pad_oe[0*BANK_W +: BANK_W])
  );

  // Bank B pin-value sampling.
  pin_sampler #(
    .W    (BANK_W),
    .MASK (BANK_MASK[1])
  ) sampler_b (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .pad_in     (pad_in[1*BANK_W +: BANK_W]),
    .analog_sel (analog_pin_config[1*BANK_W +: BANK_W]),
    .pins_q     (pins_q[1])
  );

  // Bank B output multiplexers.
  pad_driver #(
    .W    (BANK_W),
    .MASK (BANK_MASK[1])
  ) driver_b (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .dir           (dir_q[1]),
    .lat           (lat_q[1]),
    .periph_active (periph_active[1*BANK_W +: BANK_W]),
    .periph_data   (periph_data[1*BANK_W +: BANK_W]),
    .pad_out_q     (pad_out[1*BANK_W +: BANK_W]),
    .pad_oe_q      (pad_oe[1*BANK_W +: BANK_W])
  );

  // Bank C pin-value sampling.
  pin_sampler #(
    .W    (BANK_W),
    .MASK (BANK_MASK[2])
  ) sampler_c (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .pad_in     (pad_in[2*BANK_W +: BANK_W]),
    .analog_sel (analog_pin_config[2*BANK_W +: BANK_W]),
    .pins_q     (pins_q[2])
  );

  // Bank C output multiplexers.
  pad_driver #(
    .W    (BANK_W),
    .MASK (BANK_MASK[2])
  ) driver_c (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .dir           (dir_q[2]),
    .lat           (lat_q[2]),
    .periph_active (periph_active[2*BANK_W +: BANK_W]),
    .periph_data   (periph_data[2*BANK_W +: BANK_W]),
    .pad_out_q     (pad_out[2*BANK_W +: BANK_W]),
    .pad_oe_q      (pad_oe[2*BANK_W +: BANK_W])
  );

  // Bank D pin-value sampling.
  pin_sampler #(
    .W    (BANK_W),
    .MASK (BANK_MASK[3])
  ) sampler_d (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .pad_in     (pad_in[3*BANK_W +: BANK_W]),
    .analog_sel (analog_pin_config[3*BANK_W +: BANK_W]),
    .pins_q     (pins_q[3])
  );

  // Bank D output multiplexers.
  pad_driver #(
    .W    (BANK_W),
    .MASK (BANK_MASK[3])
  ) driver_d (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .dir           (dir_q[3]),
    .lat           (lat_q[3]),
    .periph_active (periph_active[3*BANK_W +: BANK_W]),
    .periph_data   (periph_data[3*BANK_W +: BANK_W]),
    .pad_out_q     (pad_out[3*BANK_W +: BANK_W]),
    .pad_oe_q      (pad_oe[3*BANK_W +: BANK_W])
  );

  // Bank E pin-value sampling.
  pin_sampler #(
    .W    (BANK_W),
    .MASK (BANK_MASK[4])
  ) sampler_e (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .pad_in     (pad_in[4*BANK_W +: BANK_W]),
    .analog_sel (analog_pin_config[4*BANK_W +: BANK_W]),
    .pins_q     (pins_q[4])
  );

  // Bank E output multiplexers.
  pad_driver #(
    .W    (BANK_W),
    .MASK (BANK_MASK[4])
  ) driver_e (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .dir           (dir_q[4]),
    .lat           (lat_q[4]),
    .periph_active (periph_active[4*BANK_W +: BANK_W]),
    .periph_data   (periph_data[4*BANK_W +: BANK_W]),
    .pad_out_q     (pad_out[4*BANK_W +: BANK_W]),
    .pad_oe_q      (pad_oe[4*BANK_W +: BANK_W])
  );

  // Bank F pin-value sampling.
  pin_sampler #(
    .W    (BANK_W),
    .MASK (BANK_MASK[5])
  ) sampler_f (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .pad_in     (pad_in[5*BANK_W +: BANK_W]),
    .analog_sel (analog_pin_config[5*BANK_W +: BANK_W]),
    .pins_q     (pins_q[5])
  );

  // Bank F output multiplexers.
  pad_driver #(
    .W    (BANK_W),
    .MASK (BANK_MASK[5])
  ) driver_f (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .dir           (dir_q[5]),
    .lat           (lat_q[5]),
    .periph_active (periph_active[5*BANK_W +: BANK_W]),
    .periph_data   (periph_data[5*BANK_W +: BANK_W]),
    .pad_out_q     (pad_out[5*BANK_W +: BANK_W]),
    .pad_oe_q      (pad_oe[5*BANK_W +: BANK_W])
  );

  // Bank G pin-value sampling.
  pin_sampler #(
    .W    (BANK_W),
    .MASK (BANK_MASK[6])
  ) sampler_g (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .pad_in     (pad_in[6*BANK_W +: BANK_W]),
    .analog_sel (analog_pin_config[6*BANK_W +: BANK_W]),
    .pins_q     (pins_q[6])
  );

  // Bank G output multiplexers.
  pad_driver #(
    .W    (BANK_W),
    .MASK (BANK_MASK[6])
  ) driver_g (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .dir           (dir_q[6]),
    .lat           (lat_q[6]),
    .periph_active (periph_active[6*BANK_W +: BANK_W]),
    .periph_data   (periph_data[6*BANK_W +: BANK_W]),
    .pad_out_q     (pad_out[6*BANK_W +: BANK_W]),
    .pad_oe_q      (pad_oe[6*BANK_W +: BANK_W])
  );

endmodule : shared_gpio_port

// >>> hdl/gpio_port_pkg.sv
// Shared constants for the general-purpose port bank: register indices, masks, resets.
// Assumes one system clock and a simple single-cycle register port.
package gpio_port_pkg;

  localparam int NUM_BANKS = 7;
  localparam int BANK_W    = 16;
  localparam int ADDR_W    = 12;
  localparam int IDX_W     = 10;
  localparam int BANK_SEL_W = 3;

  // Register indices; the byte address is four times the index. Element 0 is bank A.
  localparam logic [NUM_BANKS-1:0][IDX_W-1:0] DIR_IDX = {
    10'h2E4, 10'h2EE, 10'h2D8, 10'h2D2, 10'h2CC, 10'h2C6, 10'h2C0
  };
  localparam logic [NUM_BANKS-1:0][IDX_W-1:0] PINS_IDX = {
    10'h2E6, 10'h2ED, 10'h2DA, 10'h2D4, 10'h2CE, 10'h2C8, 10'h2C2
  };
  localparam logic [NUM_BANKS-1:0][IDX_W-1:0] LATCH_IDX = {
    10'h2E8, 10'h2E0, 10'h2DC, 10'h2D6, 10'h2D0, 10'h2CB, 10'h2C4
  };

  // Implemented pins of each bank; also the direction value after reset.
  localparam logic [NUM_BANKS-1:0][BANK_W-1:0] IMPL_MASK = {
    16'h03CC, 16'h007F, 16'h00FF, 16'h0FFF, 16'hE000, 16'hFFFF, 16'h0000
  };

  localparam logic [BANK_W-1:0] LATCH_RST = 16'h0000;
  localparam logic [BANK_W-1:0] PINS_RST  = 16'h0000;
  localparam logic [BANK_W-1:0] RDATA_RST = 16'h0000;

  typedef enum logic [1:0] {
    KIND_DIR   = 2'b00,
    KIND_PINS  = 2'b01,
    KIND_LATCH = 2'b10,
    KIND_NONE  = 2'b11
  } reg_kind_t;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [IDX_W-1:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction : byte_addr

endpackage : gpio_port_pkg

// >>> hdl/pin_sampler.sv
// Samples one bank of pad levels into the pin-value register every clock.
// Assumes pad inputs are already synchronous to clk_sys.
module pin_sampler
  import gpio_port_pkg::*;
#(
  parameter int              W    = 16,
  parameter logic [W-1:0]    MASK = '1
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic [W-1:0]  pad_in,
  input  wire logic [W-1:0]  analog_sel,
  output logic      [W-1:0]  pins_q
);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pins_q <= '0;
    end else begin
      pins_q <= pad_in & ~analog_sel & MASK;
    end
  end

endmodule : pin_sampler

// >>> hdl/pad_driver.sv
// Output data and enable multiplexers for one bank of shared pads, registered.
// Assumes the peripheral raises its active bit for every pin it currently drives.
module pad_driver
  import gpio_port_pkg::*;
#(
  parameter int              W    = 16,
  parameter logic [W-1:0]    MASK = '1
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic [W-1:0]  dir,
  input  wire logic [W-1:0]  lat,
  input  wire logic [W-1:0]  periph_active,
  input  wire logic [W-1:0]  periph_data,
  output logic      [W-1:0]  pad_out_q,
  output logic      [W-1:0]  pad_oe_q
);

  // A pin with only an input-side peripheral never raises active, so the port owns it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pad_out_q <= '0;
      pad_oe_q  <= '0;
    end else begin
      pad_out_q <= ((periph_active & periph_data) | (~periph_active & lat)) & MASK;
      pad_oe_q  <= (periph_active | ~dir) & MASK;
    end
  end

endmodule : pad_driver

// >>> bench/shared_gpio_port_checker.sv
// Port-level assertions for the shared port bank.
// Assumes bank B pins sit at byte address B20.
module shared_gpio_port_checker
  import gpio_port_pkg::*;
#(
  parameter logic [NUM_BANKS-1:0][BANK_W-1:0] BANK_MASK = IMPL_MASK
) (
  input wire logic                        clk_sys,
  input wire logic                        rst_n,
  input wire logic [ADDR_W-1:0]           reg_addr,
  input wire logic [BANK_W-1:0]           reg_wdata,
  input wire logic                        reg_write,
  input wire logic                        reg_read,
  input wire logic [BANK_W-1:0]           reg_rdata,
  input wire logic [NUM_BANKS*BANK_W-1:0] pad_in,
  input wire logic [NUM_BANKS*BANK_W-1:0] pad_out,
  input wire logic [NUM_BANKS*BANK_W-1:0] pad_oe,
  input wire logic [NUM_BANKS*BANK_W-1:0] periph_active,
  input wire logic [NUM_BANKS*BANK_W-1:0] periph_data,
  input wire logic [NUM_BANKS*BANK_W-1:0] analog_pin_config
);
  logic [NUM_BANKS*BANK_W-1:0] m;
  logic                        wr_seen_q;
  assign m = BANK_MASK;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) wr_seen_q <= 1'b0;
    else if (reg_write) wr_seen_q <= 1'b1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == '0)
    else $error("read data outside answer cycle");
  a_periph_oe: assert property ($past(rst_n) |->
    (pad_oe & $past(periph_active) & m) == ($past(periph_active) & m)) else $error("oe lost");
  a_periph_data: assert property ($past(rst_n) |->
    ((pad_out ^ $past(periph_data)) & $past(periph_active) & m) == '0) else $error("data");
  a_unimpl_quiet: assert property (((pad_oe | pad_out) & ~m) == '0)
    else $error("unimplemented pad driven");
  a_reset_inputs: assert property ($past(rst_n) && !wr_seen_q |->
    pad_oe == ($past(periph_active) & m)) else $error("port drives after reset");
  a_unmapped_zero: assert property (reg_read && reg_addr == 12'h000 |=> reg_rdata == '0)
    else $error("unmapped read");
  a_analog_zero: assert property (reg_read && reg_addr == 12'hB20 |=>
    (reg_rdata & $past(analog_pin_config[31:16], 2)) == '0) else $error("analog bit set");
  a_pins_follow: assert property (reg_read && reg_addr == 12'hB20 && $stable(pad_in) |=>
    reg_rdata == ($past(pad_in[31:16], 2) & ~$past(analog_pin_config[31:16], 2)))
    else $error("pin read mismatch");
  c_periph: cover property (|periph_active && |pad_oe);
  c_write: cover property (reg_write);
  c_analog: cover property (reg_read && |analog_pin_config);
endmodule : shared_gpio_port_checker

bind shared_gpio_port shared_gpio_port_checker #(.BANK_MASK(BANK_MASK)) chk_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pad_in(pad_in),
  .pad_out(pad_out), .pad_oe(pad_oe), .periph_active(periph_active),
  .periph_data(periph_data), .analog_pin_config(analog_pin_config));

// >>> bench/pad_partner.sv
// External pads: a driven pad shows the port's level, an undriven one the outside level.
// Assumes the outside level is set by the bench.
module pad_partner (
  input  wire logic [111:0] pad_out,
  input  wire logic [111:0] pad_oe,
  input  wire logic [111:0] ext_level,
  output logic      [111:0] pad_in
);
  timeunit 1ns;
  timeprecision 100ps;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule : pad_partner

// >>> bench/shared_gpio_port_bench.sv
// Self-checking bench for the shared port bank through bank B, C and D registers and the direction registers of all seven banks.
// Assumes the checker is bound to the design.
module shared_gpio_port_bench
  import gpio_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst_n, reg_write, reg_read;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [111:0] pad_in, pad_out, pad_oe, periph_active, periph_data, analog_q, ext_q;
  int num_errors = 0;
  int compares = 0;
  shared_gpio_port shared_gpio_port_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .periph_active(periph_active), .periph_data(periph_data), .analog_pin_config(analog_q));
  pad_partner pad_partner_inst (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_q),
    .pad_in(pad_in));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a; reg_wdata <= v; reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys);
    reg_addr <= a; reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : rd
  task automatic t_reset();
    rd(12'hB18); chk(d, IMPL_MASK[1]);
    rd(12'hB30); chk(d, IMPL_MASK[2]);
    rd(12'hB00); chk(d, 16'h0000);
    rd(12'hB48); chk(d, IMPL_MASK[3]);
    rd(12'hB60); chk(d, IMPL_MASK[4]);
    rd(12'hBB8); chk(d, IMPL_MASK[5]);
    rd(12'hB90); chk(d, IMPL_MASK[6]);
  endtask : t_reset
  task automatic t_latch_dir();
    wr(12'hB2C, 16'hA5C3); rd(12'hB2C); chk(d, 16'hA5C3);
    wr(12'hB18, 16'h00FF);
    ext_q[31:16] <= 16'h5A3C;
    repeat (3) @(posedge clk_sys);
    chk(pad_oe[31:16], 16'hFF00);
    rd(12'hB20); chk(d, 16'hA53C);
  endtask : t_latch_dir
  task automatic t_pins_write();
    wr(12'hB20, 16'h1234); rd(12'hB2C); chk(d, 16'h1234);
    wr(12'hB40, 16'hFFFF); rd(12'hB40); chk(d, 16'hE000);
    rd(12'h000); chk(d, 16'h0000);
  endtask : t_pins_write
  task automatic t_periph();
    @(posedge clk_sys);
    periph_active[24] <= 1'b1; periph_data[24] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(12'hB20); chk(d, 16'h133C);
    @(posedge clk_sys);
    periph_active[24] <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(16'({pad_oe[24], pad_out[24]}), 16'h0002);
  endtask : t_periph
  task automatic t_mid_reset();
    wr(12'hB48, 16'h0000);
    repeat (2) @(posedge clk_sys);
    chk(pad_oe[63:48], 16'h0FFF);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(12'hB48);
    chk(d, IMPL_MASK[3]);
    chk(pad_oe[63:48], 16'h0000);
    rd(12'hB2C);
    chk(d, LATCH_RST);
  endtask : t_mid_reset
  task automatic t_analog();
    wr(12'hB18, 16'hFFFF); analog_q[31:16] <= 16'hFF00;
    repeat (3) @(posedge clk_sys);
    rd(12'hB20); chk(d, 16'h003C);
  endtask : t_analog
  initial begin
    {rst_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
    {periph_active, periph_data, analog_q, ext_q} = '0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset(); t_latch_dir(); t_pins_write(); t_periph(); t_analog();
    t_mid_reset();
    tally_and_finish();
  end
  initial begin
    repeat (2000) @(posedge clk_sys);
    num_errors++;
    tally_and_finish();
  end
endmodule : shared_gpio_port_bench
